// [verilog/osd_char_attribute_decode.sv]
// Purpose: display RAM character entry store and per-mode attribute decode
// Assumes: CPU write port and display read port synchronous to core_clk
// Notes: outputs registered one cycle after the display or CPU read address
`timescale 1ns/100ps
`include "osd_defs.svh"
module osd_char_attribute_decode import osd_pkg::*; #(
	parameter int ADDR_W = 6
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [1:0] mode,
	input wire logic caption_bank_high,
	input wire logic cpu_we,
	input wire logic [1:0] cpu_sel,
	input wire logic [ADDR_W-1:0] cpu_addr,
	input wire logic [9:0] cpu_wdata,
	input wire logic [ADDR_W-1:0] cpu_raddr,
	input wire logic [1:0] cpu_rsel,
	output logic [9:0] cpu_rdata_reg,
	input wire logic [ADDR_W-1:0] disp_addr,
	input wire logic [3:0] font_pal,
	output char_attr_s attr_reg,
	output logic [3:0] dot_pal_reg
);
	localparam int DEPTH = 1 << ADDR_W;

	// ------------------------------
	// entry storage
	// ------------------------------
	logic [`CHAR_IDX_W-1:0] char_mem [DEPTH];
	logic [`COLOR1_W-1:0] color1_mem [DEPTH];
	logic [`COLOR2_W-1:0] color2_mem [DEPTH];

	// character writes keep all 10 bits; colour writes keep only their low 8 or 3 bits
	always_ff @(posedge core_clk) begin
		if (cpu_we) begin
			case (cpu_sel)
				2'b00: char_mem[cpu_addr] <= cpu_wdata;
				2'b01: color1_mem[cpu_addr] <= cpu_wdata[`COLOR1_W-1:0];
				2'b10: color2_mem[cpu_addr] <= cpu_wdata[`COLOR2_W-1:0];
				default: ;
			endcase
		end
	end

	// ------------------------------
	// cpu read back
	// ------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cpu_rdata_reg <= 10'h000;
		end else begin
			case (cpu_rsel)
				2'b00: cpu_rdata_reg <= char_mem[cpu_raddr];
				2'b01: cpu_rdata_reg <= {2'h0, color1_mem[cpu_raddr]};
				2'b10: cpu_rdata_reg <= {7'h00, color2_mem[cpu_raddr]};
				default: cpu_rdata_reg <= 10'h000;
			endcase
		end
	end

	// ------------------------------
	// decode
	// ------------------------------
	logic [9:0] cw;
	logic [7:0] c1;
	logic [2:0] c2;
	char_attr_s attr_next;
	logic [3:0] char_pal;
	logic [3:0] dot_pal_next;

	assign cw = char_mem[disp_addr];
	assign c1 = color1_mem[disp_addr];
	assign c2 = color2_mem[disp_addr];
	assign char_pal = c1[6:3];

	dot_palette_pick u_pick (
		.font_pal(font_pal),
		.char_pal(char_pal),
		.dot_pal(dot_pal_next)
	);

	always_comb begin
		attr_next = '0;
		attr_next.secondary_blank_output = c1[7];
		case (disp_mode_e'(mode))
			caption_display_mode: begin
				attr_next.char_index = cw;
				attr_next.fg_pal = {1'b0, c1[3], c1[2:1]} |
					(caption_bank_high ? `CAPTION_HIGH_BANK : 4'h0);
				attr_next.bg_pal = {1'b0, c2[2:0]} |
					(caption_bank_high ? `CAPTION_HIGH_BANK : 4'h0);
				attr_next.italic = c1[4];
				attr_next.flash = c1[5];
				attr_next.underline = c1[6];
			end
			text_display_modes: begin
				attr_next.char_index = cw;
				attr_next.fg_pal = {c1[4], c1[3], c1[2:1]};
				attr_next.bg_pal = {c2[1:0], c1[6:5]};
			end
			colour_dot_font_mode: begin
				attr_next.char_index = {3'h0, cw[`CD_CODE_W-1:0]};
				attr_next.fg_pal = char_pal;
			end
			default: ;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			attr_reg <= '0;
			dot_pal_reg <= 4'h0;
		end else begin
			attr_reg <= attr_next;
			dot_pal_reg <= (disp_mode_e'(mode) == colour_dot_font_mode) ?
				dot_pal_next : font_pal;
		end
	end
endmodule : osd_char_attribute_decode

// [verilog/osd_defs.svh]
// Purpose: constants for the character entry decoder
// Assumes: character word 9 bits + top bit, colour word 1 is 8 bits, colour word 2 is 3 bits
// Notes: colour word 2 bits 3..7 are not stored
`ifndef OSD_DEFS_SVH
`define OSD_DEFS_SVH
`define CHAR_LOW_W 9
`define CHAR_IDX_W 10
`define CD_CODE_W 7
`define COLOR1_W 8
`define COLOR2_W 3
`define PAL_W 4
`define CAPTION_HIGH_BANK 4'h8
`endif

// [verilog/osd_pkg.sv]
// Purpose: types for the character entry decoder
// Assumes: osd_defs.svh constants
// Notes: none
package osd_pkg;
	typedef enum logic [1:0] {
		caption_display_mode = 2'b00,
		text_display_modes = 2'b01,
		colour_dot_font_mode = 2'b10,
		mode_spare = 2'b11
	} disp_mode_e;

	typedef struct packed {
		logic [9:0] char_index;
		logic [3:0] fg_pal;
		logic [3:0] bg_pal;
		logic italic;
		logic flash;
		logic underline;
		logic secondary_blank_output;
	} char_attr_s;
endpackage : osd_pkg

// [verilog/dot_palette_pick.sv]
// Purpose: per-dot palette choice in colour-dot mode
// Assumes: font data gives a 4-bit palette per dot
// Notes: combinational leaf
`timescale 1ns/100ps
`include "osd_defs.svh"
module dot_palette_pick (
	input wire logic [3:0] font_pal,
	input wire logic [3:0] char_pal,
	output logic [3:0] dot_pal
);
	always_comb begin
		dot_pal = (font_pal == 4'h0) ? char_pal : font_pal;
	end
endmodule : dot_palette_pick

// [tb/osd_monitor.sv]
// Purpose: port checker
// Assumes: osd_pkg
// Notes: bound below
`timescale 1ns/100ps
module osd_monitor import osd_pkg::*; #(parameter int ADDR_W = 6) (
	input wire logic core_clk, rst, cpu_we, caption_bank_high,
	input wire logic [1:0] mode, cpu_sel, cpu_rsel,
	input wire logic [ADDR_W-1:0] cpu_addr, cpu_raddr,
	input wire logic [9:0] cpu_wdata, cpu_rdata_reg,
	input wire logic [3:0] font_pal, dot_pal_reg,
	input wire char_attr_s attr_reg
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_wr; cpu_we && cpu_sel == 2'h1; endsequence
	sequence s_rd; cpu_rsel == 2'h1 && cpu_raddr == $past(cpu_addr) && !cpu_we; endsequence
	a_kept_bits: assert property (s_wr ##1 s_rd |=>
		cpu_rdata_reg[7:0] == $past(cpu_wdata[7:0], 2)) else $error("rd");
	a_cd_index: assert property (mode == 2'h2 |=> !attr_reg[21:19]) else $error("ci");
	a_dot_font: assert property (mode == 2'h2 && font_pal |=>
		dot_pal_reg == $past(font_pal)) else $error("df");
	a_dot_pass: assert property (mode != 2'h2 |=>
		dot_pal_reg == $past(font_pal)) else $error("dp");
	a_no_style: assert property (mode |=> !attr_reg[3:1]) else $error("st");
	a_bank_high: assert property (!mode && caption_bank_high |=>
		attr_reg[11] && attr_reg[7]) else $error("bh");
	a_bank_low: assert property (!mode && !caption_bank_high |=> !attr_reg[11])
		else $error("bl");
	a_bad_sel: assert property (&cpu_rsel |=> !cpu_rdata_reg) else $error("rs");
endmodule : osd_monitor
bind osd_char_attribute_decode osd_monitor #(.ADDR_W(ADDR_W)) mon (.*);

// [tb/cpu_model.sv]
// Purpose: cpu write model
// Assumes: one write a strobe
// Notes: idle data inverted
`timescale 1ns/100ps
module cpu_model (
	input wire logic core_clk,
	output logic cpu_we = 0,
	output logic [1:0] cpu_sel = 0,
	output logic [5:0] cpu_addr = 0,
	output logic [9:0] cpu_wdata = 0
);
	task automatic wr(input logic [1:0] s, input logic [9:0] d);
		@(posedge core_clk);
		{cpu_we, cpu_sel, cpu_addr, cpu_wdata} <= {1'b1, s, 6'h03, d};
		@(posedge core_clk);
		{cpu_we, cpu_wdata} <= {1'b0, ~d};
	endtask : wr
endmodule : cpu_model

// [tb/osd_char_attribute_decode_bench.sv]
// Purpose: decoder bench
// Assumes: one cycle latency
// Notes: rows, then edge cases
`timescale 1ns/100ps
module osd_char_attribute_decode_bench import osd_pkg::*;;
	logic core_clk = 0, rst = 1, bank = 0, cpu_we;
	logic [1:0] mode = 0, cpu_sel, rsel = 0;
	logic [5:0] cpu_addr, ra = 3;
	logic [9:0] cpu_wdata, rd;
	logic [3:0] fp = 0, dp;
	char_attr_s attr;
	int n_errors = 0, num_checks = 0;
	logic [24:0] rows [4] = '{{3'h0, 22'h2A555D}, {3'h1, 22'h2A5DDD}, {3'h2, 22'h2A5D51},
		{3'h6, 22'h000001}};
	always #2 core_clk = ~core_clk;
	cpu_model cpu (.*);
	osd_char_attribute_decode DUT (.*, .caption_bank_high(bank), .cpu_raddr(ra), .cpu_rsel(rsel),
		.cpu_rdata_reg(rd), .disp_addr(ra), .font_pal(fp), .attr_reg(attr), .dot_pal_reg(dp));
	task automatic chk(input logic [21:0] g, e);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : tick
	task automatic close_out;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : close_out
	initial begin
		repeat (16) @(posedge core_clk);
		rst <= 0;
		cpu.wr(2'h0, 10'h2A5);
		cpu.wr(2'h1, 10'h0BA);
		cpu.wr(2'h2, 10'h005);
		foreach (rows[i]) begin
			@(posedge core_clk);
			{mode, bank} <= rows[i][24:22];
			tick(1);
			chk(attr, rows[i][21:0]);
			$display("row %0d", i);
		end
		@(posedge core_clk);
		{mode, fp} <= {2'h2, 4'h0};
		tick(1);
		chk(attr.char_index, 10'h025);
		chk(dp, 4'h7);
		@(posedge core_clk);
		fp <= 4'h9;
		tick(1);
		chk(dp, 4'h9);
		$display("dot");
		cpu.wr(2'h1, 10'h0BB);
		rsel <= 2'h1;
		tick(2);
		chk(rd[7:0], 8'hBB);
		@(posedge core_clk);
		rsel <= 2'h2;
		tick(1);
		chk(rd[2:0], 3'h5);
		@(posedge core_clk);
		rsel <= 2'h3;
		tick(1);
		chk(rd, 10'h000);
		$display("reads");
		@(posedge core_clk);
		rst <= 1;
		tick(1);
		chk(attr, 22'h0);
		chk({18'h0, dp}, 22'h0);
		$display("reset");
		close_out();
	end
endmodule : osd_char_attribute_decode_bench
